// ---- design/strap_pad_mux.sv ----
// Purpose: strap sampling/decode and per-pad function mux for radio pads
// Assumes: all inputs synchronous to clk; pad levels include board pulls
// Notes: pads stay undriven until the strap sample is taken
module strap_pad_mux #(
  parameter int STRAP_DELAY = pad_mux_pkg::STRAP_DELAY_CYC,
  parameter int CNT_W = pad_mux_pkg::STRAP_CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ext_por_n,
  input wire logic host_sel_strap,
  input wire logic pad_voltage_strap,
  input wire logic cpu_free_strap,
  input wire logic generic_serial_periph_mode_sel_strap,
  input wire logic [pad_mux_pkg::NUM_PADS-1:0][3:0] pad_func,
  input wire logic [pad_mux_pkg::NUM_PADS-1:0] pad_i,
  output logic [pad_mux_pkg::NUM_PADS-1:0] pad_o,
  output logic [pad_mux_pkg::NUM_PADS-1:0] pad_oe,
  input wire pad_mux_pkg::core_out_t core_out,
  output pad_mux_pkg::core_in_t core_in,
  input wire logic radio_slot_active,
  output logic coex_rf_activity,
  output logic radio_tx_allowed,
  output logic strap_done,
  output pad_mux_pkg::host_mode_t host_mode,
  output logic generic_serial_periph_mode,
  output logic io_3v3,
  output logic cpu_free
);
  localparam int P = pad_mux_pkg::NUM_PADS;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STRAP_DELAY - 1);

  if (STRAP_DELAY < 1 || STRAP_DELAY >= (2 ** CNT_W)) begin : g_chk
    $error("strap delay does not fit the counter");
  end
  // ==========================================================
  // strap sampling
  pad_mux_pkg::strap_state_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic host_sel_r, volt_sel_r, cpu_free_r, generic_serial_periph_mode_sel_r;
  wire sample_now = (st_r == pad_mux_pkg::ST_WAIT) && (cnt_r == CNT_LAST);
  pad_mux_pkg::host_mode_t mode_nxt;
  logic v33_nxt;

  // decode of the live pins, captured at the sample instant only
  assign mode_nxt = host_sel_strap ? pad_mux_pkg::HOST_SDIO :
                    generic_serial_periph_mode_sel_strap ? pad_mux_pkg::HOST_GENERIC_SERIAL_PERIPH_MODE : pad_mux_pkg::HOST_UNSUP;
  assign v33_nxt = (!host_sel_strap && !generic_serial_periph_mode_sel_strap) ? 1'b1 : pad_voltage_strap;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= pad_mux_pkg::ST_WAIT;
      cnt_r <= '0;
    end else if (ce) begin
      if (!ext_por_n) begin
        st_r <= pad_mux_pkg::ST_WAIT;
        cnt_r <= '0;
      end else begin
        case (st_r)
          pad_mux_pkg::ST_WAIT: begin
            if (sample_now) begin
              st_r <= pad_mux_pkg::ST_DONE;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
          pad_mux_pkg::ST_DONE: st_r <= pad_mux_pkg::ST_DONE;
          default: st_r <= pad_mux_pkg::ST_WAIT;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_sel_r <= pad_mux_pkg::HOST_SEL_RST;
      volt_sel_r <= pad_mux_pkg::VOLT_SEL_RST;
      cpu_free_r <= pad_mux_pkg::CPU_FREE_RST;
      generic_serial_periph_mode_sel_r <= pad_mux_pkg::GENERIC_SERIAL_PERIPH_MODE_SEL_RST;
      host_mode <= pad_mux_pkg::HOST_SDIO;
      io_3v3 <= 1'b0;
    end else if (ce && ext_por_n && sample_now) begin
      host_sel_r <= host_sel_strap;
      volt_sel_r <= pad_voltage_strap;
      cpu_free_r <= cpu_free_strap;
      generic_serial_periph_mode_sel_r <= generic_serial_periph_mode_sel_strap;
      host_mode <= mode_nxt;
      io_3v3 <= v33_nxt;
    end
  end

  assign strap_done = (st_r == pad_mux_pkg::ST_DONE);
  assign cpu_free = cpu_free_r;
  assign generic_serial_periph_mode = (host_mode == pad_mux_pkg::HOST_GENERIC_SERIAL_PERIPH_MODE);

  // ==========================================================
  // output mux: drv = {level, enable}, 00 means undriven
  wire [1:0] gd [8];
  wire [1:0] ad [8];
  for (genvar k = 0; k < 8; k++) begin : g_gp
    assign gd[k] = {core_out.gpio_o[k], core_out.gpio_oe[k]};
    assign ad[k] = {core_out.agpio_o[k], core_out.agpio_oe[k]};
  end
  wire [P-1:0][3:0] f = pad_func;
  wire pm = core_out.pcm_master;
  logic [1:0] drv [P];
  always_comb begin
    for (int i = 0; i < P; i++) begin
      drv[i] = 2'b00;
    end
    case (f[pad_mux_pkg::P_CTS])
      pad_mux_pkg::FN_ALT7: drv[pad_mux_pkg::P_CTS] = ad[1];
      default: ;
    endcase
    case (f[pad_mux_pkg::P_RTS])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_RTS] = {core_out.uart_rts_n, 1'b1};
      pad_mux_pkg::FN_ALT7: drv[pad_mux_pkg::P_RTS] = ad[0];
      default: ;
    endcase
    case (f[pad_mux_pkg::P_RXD])
      pad_mux_pkg::FN_ALT7: drv[pad_mux_pkg::P_RXD] = gd[5];
      default: ;
    endcase
    case (f[pad_mux_pkg::P_TXD])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_TXD] = {core_out.uart_txd, 1'b1};
      pad_mux_pkg::FN_ALT7: drv[pad_mux_pkg::P_TXD] = gd[4];
      default: ;
    endcase
    case (f[pad_mux_pkg::P_PIN])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_PIN] = ad[3];
      pad_mux_pkg::FN_HCLK: drv[pad_mux_pkg::P_PIN] = {core_out.hclk, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_POUT])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_POUT] = ad[2];
      pad_mux_pkg::FN_PCM, pad_mux_pkg::FN_PCM2: drv[pad_mux_pkg::P_POUT] = {core_out.pcm_out, 1'b1};
      pad_mux_pkg::FN_HCLK: drv[pad_mux_pkg::P_POUT] = {core_out.link_indicator, 1'b1};
      pad_mux_pkg::FN_I2SM: drv[pad_mux_pkg::P_POUT] = {core_out.i2s_msdo, 1'b1};
      pad_mux_pkg::FN_ALT7: drv[pad_mux_pkg::P_POUT] = {core_out.i2s_ssdo, 1'b1};
      pad_mux_pkg::FN_FLASH: drv[pad_mux_pkg::P_POUT] = {core_out.flash_data_out, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_PSYNC])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_PSYNC] = ad[1];
      pad_mux_pkg::FN_PCM, pad_mux_pkg::FN_PCM2: drv[pad_mux_pkg::P_PSYNC] = {core_out.pcm_sync, pm};
      pad_mux_pkg::FN_HCLK: drv[pad_mux_pkg::P_PSYNC] = {core_out.hclk, 1'b1};
      pad_mux_pkg::FN_ALT4: drv[pad_mux_pkg::P_PSYNC] = {core_out.low_power_osc_out, 1'b1};
      pad_mux_pkg::FN_I2SM: drv[pad_mux_pkg::P_PSYNC] = {core_out.i2s_mws, 1'b1};
      pad_mux_pkg::FN_FLASH: drv[pad_mux_pkg::P_PSYNC] = {core_out.flash_chip_select_n, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_PCLK])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_PCLK] = ad[0];
      pad_mux_pkg::FN_PCM, pad_mux_pkg::FN_PCM2: drv[pad_mux_pkg::P_PCLK] = {core_out.pcm_clk, pm};
      pad_mux_pkg::FN_I2SM: drv[pad_mux_pkg::P_PCLK] = {core_out.audio_master_clock_out, 1'b1};
      pad_mux_pkg::FN_FLASH: drv[pad_mux_pkg::P_PCLK] = {core_out.flash_serial_clock, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_SDO])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_SDO] = ad[5];
      pad_mux_pkg::FN_PCM: drv[pad_mux_pkg::P_SDO] = {core_out.pcm_out, 1'b1};
      pad_mux_pkg::FN_ALT4: drv[pad_mux_pkg::P_SDO] = {core_out.i2s_ssdo, 1'b1};
      pad_mux_pkg::FN_I2SM: drv[pad_mux_pkg::P_SDO] = {core_out.i2s_msdo, 1'b1};
      pad_mux_pkg::FN_ALT7: drv[pad_mux_pkg::P_SDO] = {core_out.status, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_SDI])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_SDI] = ad[6];
      pad_mux_pkg::FN_HCLK: drv[pad_mux_pkg::P_SDI] = {core_out.hclk, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_SWS])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_SWS] = gd[7];
      pad_mux_pkg::FN_PCM: drv[pad_mux_pkg::P_SWS] = {core_out.pcm_sync, pm};
      pad_mux_pkg::FN_HCLK: drv[pad_mux_pkg::P_SWS] = {core_out.link_indicator, 1'b1};
      pad_mux_pkg::FN_I2SM: drv[pad_mux_pkg::P_SWS] = {core_out.i2s_mws, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_SCLK])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_SCLK] = gd[6];
      pad_mux_pkg::FN_PCM: drv[pad_mux_pkg::P_SCLK] = {core_out.pcm_clk, pm};
      pad_mux_pkg::FN_ALT4: drv[pad_mux_pkg::P_SCLK] = {core_out.low_power_osc_out, 1'b1};
      pad_mux_pkg::FN_I2SM: drv[pad_mux_pkg::P_SCLK] = {core_out.audio_master_clock_out, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_G1])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_G1] = gd[1];
      pad_mux_pkg::FN_ALT7: drv[pad_mux_pkg::P_G1] = {core_out.class1_2, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_G0])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_G0] = gd[0];
      pad_mux_pkg::FN_ALT4: drv[pad_mux_pkg::P_G0] = {core_out.clk_12p288, 1'b1};
      default: ;
    endcase
    case (f[pad_mux_pkg::P_CREQ])
      pad_mux_pkg::FN_BASE: drv[pad_mux_pkg::P_CREQ] = {core_out.clk_req, 1'b1};
      pad_mux_pkg::FN_ALT7: drv[pad_mux_pkg::P_CREQ] = ad[7];
      default: ;
    endcase
  end

  // ==========================================================
  // input routing; a pad not in a matching mode reads as 0, except uart_cts_n and uart_rxd which read as 1
  wire [P-1:0] p = pad_i;
  wire on_pcm_pin = (f[pad_mux_pkg::P_PIN] == pad_mux_pkg::FN_PCM) || (f[pad_mux_pkg::P_PIN] == pad_mux_pkg::FN_PCM2);
  wire on_pcm_sync = (f[pad_mux_pkg::P_PSYNC] == pad_mux_pkg::FN_PCM) || (f[pad_mux_pkg::P_PSYNC] == pad_mux_pkg::FN_PCM2);
  wire on_pcm_clk = (f[pad_mux_pkg::P_PCLK] == pad_mux_pkg::FN_PCM) || (f[pad_mux_pkg::P_PCLK] == pad_mux_pkg::FN_PCM2);
  wire coex_sel = (f[pad_mux_pkg::P_SDI] == pad_mux_pkg::FN_ALT7);
  pad_mux_pkg::core_in_t cin;

  always_comb begin
    cin = '0;
    cin.uart_cts_n = (f[pad_mux_pkg::P_CTS] == pad_mux_pkg::FN_BASE) ? p[pad_mux_pkg::P_CTS] : 1'b1;
    cin.uart_rxd = (f[pad_mux_pkg::P_RXD] == pad_mux_pkg::FN_BASE) ? p[pad_mux_pkg::P_RXD] : 1'b1;
    cin.pcm_in = on_pcm_pin ? p[pad_mux_pkg::P_PIN] :
                 (f[pad_mux_pkg::P_SDI] == pad_mux_pkg::FN_PCM) && p[pad_mux_pkg::P_SDI];
    // slave-only inputs: a master never listens to its own drive
    cin.pcm_sync = !pm && (on_pcm_sync ? p[pad_mux_pkg::P_PSYNC] :
                   (f[pad_mux_pkg::P_SWS] == pad_mux_pkg::FN_PCM) && p[pad_mux_pkg::P_SWS]);
    cin.pcm_clk = !pm && (on_pcm_clk ? p[pad_mux_pkg::P_PCLK] :
                  (f[pad_mux_pkg::P_SCLK] == pad_mux_pkg::FN_PCM) && p[pad_mux_pkg::P_SCLK]);
    cin.i2s_sdi = (f[pad_mux_pkg::P_PIN] == pad_mux_pkg::FN_ALT7) ? p[pad_mux_pkg::P_PIN] :
                  (f[pad_mux_pkg::P_SDI] == pad_mux_pkg::FN_ALT4) && p[pad_mux_pkg::P_SDI];
    cin.i2s_sws = (f[pad_mux_pkg::P_PSYNC] == pad_mux_pkg::FN_ALT7) ? p[pad_mux_pkg::P_PSYNC] :
                  (f[pad_mux_pkg::P_SWS] == pad_mux_pkg::FN_ALT7) && p[pad_mux_pkg::P_SWS];
    cin.audio_slave_clock_in = (f[pad_mux_pkg::P_PCLK] == pad_mux_pkg::FN_ALT7) ? p[pad_mux_pkg::P_PCLK] :
                               (f[pad_mux_pkg::P_SCLK] == pad_mux_pkg::FN_ALT7) && p[pad_mux_pkg::P_SCLK];
    cin.flash_data_in = (f[pad_mux_pkg::P_PIN] == pad_mux_pkg::FN_FLASH) && p[pad_mux_pkg::P_PIN];
    cin.coex_tx_grant = coex_sel && p[pad_mux_pkg::P_SDI];
    cin.gpio_i[0] = (f[pad_mux_pkg::P_G0] == pad_mux_pkg::FN_BASE) && p[pad_mux_pkg::P_G0];
    cin.gpio_i[1] = (f[pad_mux_pkg::P_G1] == pad_mux_pkg::FN_BASE) && p[pad_mux_pkg::P_G1];
    cin.gpio_i[4] = (f[pad_mux_pkg::P_TXD] == pad_mux_pkg::FN_ALT7) && p[pad_mux_pkg::P_TXD];
    cin.gpio_i[5] = (f[pad_mux_pkg::P_RXD] == pad_mux_pkg::FN_ALT7) && p[pad_mux_pkg::P_RXD];
    cin.gpio_i[6] = (f[pad_mux_pkg::P_SCLK] == pad_mux_pkg::FN_BASE) && p[pad_mux_pkg::P_SCLK];
    cin.gpio_i[7] = (f[pad_mux_pkg::P_SWS] == pad_mux_pkg::FN_BASE) && p[pad_mux_pkg::P_SWS];
    cin.agpio_i[0] = (f[pad_mux_pkg::P_PCLK] == pad_mux_pkg::FN_BASE) ? p[pad_mux_pkg::P_PCLK] :
                     (f[pad_mux_pkg::P_RTS] == pad_mux_pkg::FN_ALT7) && p[pad_mux_pkg::P_RTS];
    cin.agpio_i[1] = (f[pad_mux_pkg::P_PSYNC] == pad_mux_pkg::FN_BASE) ? p[pad_mux_pkg::P_PSYNC] :
                     (f[pad_mux_pkg::P_CTS] == pad_mux_pkg::FN_ALT7) && p[pad_mux_pkg::P_CTS];
    cin.agpio_i[2] = (f[pad_mux_pkg::P_POUT] == pad_mux_pkg::FN_BASE) && p[pad_mux_pkg::P_POUT];
    cin.agpio_i[3] = (f[pad_mux_pkg::P_PIN] == pad_mux_pkg::FN_BASE) && p[pad_mux_pkg::P_PIN];
    cin.agpio_i[5] = (f[pad_mux_pkg::P_SDO] == pad_mux_pkg::FN_BASE) && p[pad_mux_pkg::P_SDO];
    cin.agpio_i[6] = (f[pad_mux_pkg::P_SDI] == pad_mux_pkg::FN_BASE) && p[pad_mux_pkg::P_SDI];
    cin.agpio_i[7] = (f[pad_mux_pkg::P_CREQ] == pad_mux_pkg::FN_ALT7) && p[pad_mux_pkg::P_CREQ];
  end

  // ==========================================================
  // registered pad and core side; all but coex_rf_activity held idle until straps are taken
  for (genvar k = 0; k < P; k++) begin : g_pad
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pad_o[k] <= 1'b0;
        pad_oe[k] <= 1'b0;
      end else if (ce) begin
        pad_o[k] <= strap_done && drv[k][1];
        pad_oe[k] <= strap_done && drv[k][0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_in <= '0;
      coex_rf_activity <= 1'b0;
      radio_tx_allowed <= 1'b0;
    end else if (ce) begin
      core_in <= strap_done ? cin : '0;
      coex_rf_activity <= radio_slot_active;
      // without the coex pad selected there is no arbiter to wait for
      radio_tx_allowed <= strap_done && (!coex_sel || p[pad_mux_pkg::P_SDI]);
    end
  end

  // ==========================================================
  // checks
  sequence live_s;
    ce && strap_done;
  endsequence

  strap_hold_a: assert property (@(posedge clk) disable iff (rst)
    strap_done && $past(strap_done) && ext_por_n |-> $stable(host_mode) && $stable(io_3v3) && $stable(cpu_free))
    else $error("strap value changed after sampling");
  strap_time_a: assert property (@(posedge clk) disable iff (rst)
    $rose(strap_done) |-> $past(cnt_r) == CNT_LAST)
    else $error("straps sampled at wrong time");
  host_dec_a: assert property (@(posedge clk) disable iff (rst)
    ce && ext_por_n && sample_now |=> host_mode == (host_sel_r ? pad_mux_pkg::HOST_SDIO :
      (generic_serial_periph_mode_sel_r ? pad_mux_pkg::HOST_GENERIC_SERIAL_PERIPH_MODE : pad_mux_pkg::HOST_UNSUP)))
    else $error("host mode decode wrong");
  volt_dec_a: assert property (@(posedge clk) disable iff (rst)
    strap_done |-> io_3v3 == ((host_mode == pad_mux_pkg::HOST_UNSUP) ? 1'b1 : volt_sel_r))
    else $error("voltage decode wrong");
  pad_idle_a: assert property (@(posedge clk) disable iff (rst)
    !strap_done ##1 !$past(strap_done) |-> pad_oe == '0)
    else $error("pad driven before strap sample");
  gpio_base_a: assert property (@(posedge clk) disable iff (rst)
    live_s and f[pad_mux_pkg::P_G0] == pad_mux_pkg::FN_BASE |=>
      pad_o[pad_mux_pkg::P_G0] == $past(core_out.gpio_o[0]) && pad_oe[pad_mux_pkg::P_G0] == $past(core_out.gpio_oe[0]))
    else $error("gpio pad not following gpio");
  flash_cs_a: assert property (@(posedge clk) disable iff (rst)
    live_s and f[pad_mux_pkg::P_PSYNC] == pad_mux_pkg::FN_FLASH |=>
      pad_oe[pad_mux_pkg::P_PSYNC] && pad_o[pad_mux_pkg::P_PSYNC] == $past(core_out.flash_chip_select_n))
    else $error("flash select not driven");
  unassigned_a: assert property (@(posedge clk) disable iff (rst)
    ce && f[pad_mux_pkg::P_CTS] != pad_mux_pkg::FN_ALT7 |=> !pad_oe[pad_mux_pkg::P_CTS])
    else $error("unassigned pad driven");
  pcm_dir_a: assert property (@(posedge clk) disable iff (rst)
    live_s and on_pcm_clk |=> pad_oe[pad_mux_pkg::P_PCLK] == $past(pm))
    else $error("pcm clock direction wrong");
  coex_gate_a: assert property (@(posedge clk) disable iff (rst)
    ce && coex_sel && !p[pad_mux_pkg::P_SDI] |=> !radio_tx_allowed)
    else $error("transmit allowed without grant");
  rf_act_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> coex_rf_activity == $past(radio_slot_active))
    else $error("activity output wrong");
endmodule

// ---- design/pad_mux_pkg.sv ----
// Purpose: shared constants and types for strap decode and pad mux
// Assumes: 200 MHz clock, 4-bit pad function codes
// Notes: pad indices order the pad vectors of the top module
package pad_mux_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int STRAP_DELAY_MS = 2;
  localparam int STRAP_DELAY_CYC = STRAP_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STRAP_CNT_W = 20;
  // ==========================================================
  // strap reset values (internal pulls)
  localparam logic HOST_SEL_RST = 1'b1;
  localparam logic VOLT_SEL_RST = 1'b0;
  localparam logic CPU_FREE_RST = 1'b1;
  localparam logic GENERIC_SERIAL_PERIPH_MODE_SEL_RST = 1'b1;
  // ==========================================================
  // pads
  localparam int NUM_PADS = 15;
  localparam int P_CTS = 0;
  localparam int P_RTS = 1;
  localparam int P_RXD = 2;
  localparam int P_TXD = 3;
  localparam int P_PIN = 4;
  localparam int P_POUT = 5;
  localparam int P_PSYNC = 6;
  localparam int P_PCLK = 7;
  localparam int P_SDO = 8;
  localparam int P_SDI = 9;
  localparam int P_SWS = 10;
  localparam int P_SCLK = 11;
  localparam int P_G1 = 12;
  localparam int P_G0 = 13;
  localparam int P_CREQ = 14;
  // ==========================================================
  // function codes
  localparam logic [3:0] FN_BASE = 4'h0;
  localparam logic [3:0] FN_PCM = 4'h1;
  localparam logic [3:0] FN_PCM2 = 4'h2;
  localparam logic [3:0] FN_HCLK = 4'h3;
  localparam logic [3:0] FN_ALT4 = 4'h4;
  localparam logic [3:0] FN_I2SM = 4'h5;
  localparam logic [3:0] FN_ALT7 = 4'h7;
  localparam logic [3:0] FN_FLASH = 4'hf;
  // ==========================================================
  // types
  typedef enum logic [1:0] {HOST_UNSUP = 2'b00, HOST_SDIO = 2'b01, HOST_GENERIC_SERIAL_PERIPH_MODE = 2'b10} host_mode_t;
  typedef enum logic {ST_WAIT = 1'b0, ST_DONE = 1'b1} strap_state_t;
  typedef struct packed {
    logic uart_rts_n, uart_txd, pcm_out, pcm_sync, pcm_clk, pcm_master;
    logic i2s_msdo, i2s_mws, audio_master_clock_out, i2s_ssdo;
    logic link_indicator, hclk, low_power_osc_out, status, clk_req, class1_2, clk_12p288;
    logic flash_serial_clock, flash_data_out, flash_chip_select_n;
    logic [7:0] gpio_o, gpio_oe, agpio_o, agpio_oe;
  } core_out_t;
  typedef struct packed {
    logic uart_cts_n, uart_rxd, pcm_in, pcm_sync, pcm_clk;
    logic i2s_sdi, i2s_sws, audio_slave_clock_in, flash_data_in, coex_tx_grant;
    logic [7:0] gpio_i, agpio_i;
  } core_in_t;
endpackage

// ---- testbench/strap_board.sv ----
// Purpose: board side of the block: strap resistors and far ends of the radio pads
// Assumes: undriven straps settle to the internal pull level
// Notes: the far end always drives a pad the device leaves undriven, so no floating level
module strap_board (
  input wire logic [3:0] strap_drive_en,
  input wire logic [3:0] strap_drive_val,
  input wire logic [14:0] dut_o,
  input wire logic [14:0] dut_oe,
  input wire logic [14:0] far_val,
  output logic [3:0] strap_lvl,
  output logic [14:0] pad_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // straps: bit0 host, bit1 voltage, bit2 cpu-free, bit3 spi select
  localparam logic [3:0] PULLS = 4'hd;
  assign strap_lvl = (strap_drive_en & strap_drive_val) | (~strap_drive_en & PULLS);
  // ==========================================================
  // pads: far end carries the coex grant and flash data back
  assign pad_lvl = (dut_oe & dut_o) | (~dut_oe & far_val);
endmodule

// ---- testbench/strap_pad_mux_bench.sv ----
// Purpose: self-checking bench for strap decode and pad function mux
// Assumes: strap wait shortened to 8 cycles
// Notes: inputs change by non-blocking assignment at the rising edge
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module strap_pad_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, ext_por_n = 1'b1, slot = 1'b0;
  logic [3:0] sd_en = 4'h0, sd_val = 4'h0, straps;
  logic [14:0] far_val = 15'h0000, pad_lvl, pad_o, pad_oe;
  logic [14:0][3:0] func = '0;
  pad_mux_pkg::core_out_t co = '0;
  pad_mux_pkg::core_in_t ci;
  pad_mux_pkg::host_mode_t host_mode;
  logic coex_act, tx_ok, strap_done, generic_serial_periph_mode_mode, io_3v3, cpu_free;
  int fail_count = 0, n_checks = 0, cyc = 0;
  strap_board board_u (.strap_drive_en(sd_en), .strap_drive_val(sd_val), .dut_o(pad_o), .dut_oe(pad_oe),
    .far_val(far_val), .strap_lvl(straps), .pad_lvl(pad_lvl));
  strap_pad_mux #(.STRAP_DELAY(8), .CNT_W(20)) dut_u (.clk(clk), .rst(rst), .ce(ce), .ext_por_n(ext_por_n),
    .host_sel_strap(straps[0]), .pad_voltage_strap(straps[1]), .cpu_free_strap(straps[2]),
    .generic_serial_periph_mode_sel_strap(straps[3]), .pad_func(func), .pad_i(pad_lvl), .pad_o(pad_o), .pad_oe(pad_oe),
    .core_out(co), .core_in(ci), .radio_slot_active(slot), .coex_rf_activity(coex_act),
    .radio_tx_allowed(tx_ok), .strap_done(strap_done), .host_mode(host_mode),
    .generic_serial_periph_mode(generic_serial_periph_mode_mode), .io_3v3(io_3v3), .cpu_free(cpu_free));
  // ==========================================================
  // helpers
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (strap_done !== 1'b1 && k < 12) begin
      wt(1);
      k++;
    end
    `CHK(strap_done, 1'b1)
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_defaults();
    wt(6);
    `CHK(strap_done, 1'b0)
    `CHK(pad_oe, 15'h0000)
    wait_done();
    `CHK(host_mode, pad_mux_pkg::HOST_SDIO)
    `CHK(io_3v3, 1'b0)
    `CHK(cpu_free, 1'b1)
  endtask
  task automatic t_decode();
    logic h, v, g;
    pad_mux_pkg::host_mode_t m;
    for (int i = 0; i < 8; i++) begin
      h = i[0];
      v = i[1];
      g = i[2];
      m = h ? pad_mux_pkg::HOST_SDIO : (g ? pad_mux_pkg::HOST_GENERIC_SERIAL_PERIPH_MODE : pad_mux_pkg::HOST_UNSUP);
      @(posedge clk);
      sd_en <= 4'hf;
      sd_val <= {g, h, v, h};
      ext_por_n <= 1'b0;
      @(posedge clk);
      ext_por_n <= 1'b1;
      wt(2);
      `CHK(strap_done, 1'b0)
      wait_done();
      `CHK(host_mode, m)
      `CHK(generic_serial_periph_mode_mode, m == pad_mux_pkg::HOST_GENERIC_SERIAL_PERIPH_MODE)
      `CHK(io_3v3, (h | g) ? v : 1'b1)
      `CHK(cpu_free, h)
      @(posedge clk);
      sd_val <= ~{g, h, v, h};
      wt(3);
      `CHK(host_mode, m)
      `CHK(io_3v3, (h | g) ? v : 1'b1)
    end
  endtask
  task automatic t_mux();
    @(posedge clk);
    func[6] <= 4'hf;
    func[5] <= 4'hf;
    func[4] <= 4'hf;
    func[0] <= 4'h6;
    func[13] <= 4'h0;
    func[14] <= 4'h7;
    co.flash_chip_select_n <= 1'b0;
    co.flash_data_out <= 1'b1;
    co.gpio_o[0] <= 1'b1;
    co.gpio_oe[0] <= 1'b1;
    co.agpio_o[7] <= 1'b1;
    co.agpio_oe[7] <= 1'b1;
    far_val[4] <= 1'b1;
    wt(2);
    `CHK({pad_oe[6], pad_o[6], pad_oe[5], pad_o[5]}, 4'hb)
    `CHK(pad_oe[4], 1'b0)
    `CHK(ci.flash_data_in, 1'b1)
    `CHK(pad_oe[0], 1'b0)
    `CHK({pad_oe[13], pad_o[13]}, 2'h3)
    `CHK({pad_oe[14], pad_o[14]}, 2'h3)
  endtask
  task automatic t_coex();
    @(posedge clk);
    func[9] <= 4'h7;
    far_val[9] <= 1'b0;
    slot <= 1'b1;
    wt(2);
    `CHK(tx_ok, 1'b0)
    `CHK(coex_act, 1'b1)
    @(posedge clk);
    far_val[9] <= 1'b1;
    slot <= 1'b0;
    wt(2);
    `CHK(tx_ok, 1'b1)
    `CHK(coex_act, 1'b0)
  endtask
  task automatic t_audio();
    @(posedge clk);
    func[7] <= 4'h1;
    func[8] <= 4'h7;
    func[5] <= 4'h5;
    co.pcm_master <= 1'b1;
    co.pcm_clk <= 1'b1;
    co.status <= 1'b1;
    co.gpio_o[7] <= 1'b1;
    co.gpio_oe[7] <= 1'b1;
    wt(2);
    `CHK({pad_oe[7], pad_o[7], ci.pcm_clk}, 3'h6)
    `CHK({pad_oe[8], pad_o[8]}, 2'h3)
    `CHK({pad_oe[5], pad_o[5]}, 2'h2)
    `CHK({pad_oe[1], pad_o[1]}, 2'h2)
    `CHK({pad_oe[10], pad_o[10]}, 2'h3)
    // slave: clock pad released, far end clock reaches the core
    @(posedge clk);
    co.pcm_master <= 1'b0;
    co.pcm_clk <= 1'b0;
    far_val[7] <= 1'b1;
    func[9] <= 4'h0;
    wt(2);
    `CHK({pad_oe[7], ci.pcm_clk}, 2'h1)
    `CHK(ci.agpio_i[6], 1'b1)
  endtask
  // ==========================================================
  // sequence and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_decode();
    t_mux();
    t_coex();
    t_audio();
    give_verdict();
  end
endmodule
